//--- core/flash_pkg.sv
/*
 shared constants and types of the serial flash pin interface:
 opcodes, array geometry, program and erase times, link states and
 the word that carries one program byte toward the array.
 assumes a 100 MHz system clock.
*/
package flash_pkg;
   // opcodes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FREAD = 8'h0b;
   localparam logic [7:0] OP_ERASE4K = 8'h20;
   localparam logic [7:0] OP_ERASE32A = 8'h52;
   localparam logic [7:0] OP_ERASE32B = 8'hd8;
   localparam logic [7:0] OP_CHIPA = 8'h60;
   localparam logic [7:0] OP_CHIPB = 8'hc7;
   localparam logic [7:0] OP_CHIPC = 8'h62;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_OTP_READ = 8'h77;
   localparam logic [7:0] OP_OTP_PROG = 8'h9b;
   // geometry
   localparam int ADDR_W = 16;
   localparam int ARRAY_BYTES = 65536;
   localparam int OTP_BYTES = 128;
   localparam logic [15:0] MASK_4K = 16'h0fff;
   localparam logic [15:0] MASK_32K = 16'h7fff;
   localparam logic [15:0] MASK_CHIP = 16'hffff;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [1:0] ADDR_BYTES = 2'h2;
   localparam int FIFO_DEPTH = 16;
   // times in microseconds and their cycle counts
   localparam int CLK_MHZ = 100;
   localparam int PROG_TIME_US = 2500;
   localparam int ERASE4K_TIME_US = 100000;
   localparam int ERASE32K_TIME_US = 500000;
   localparam int CHIP_TIME_US = 1000000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE4K_CYCLES = ERASE4K_TIME_US * CLK_MHZ;
   localparam int ERASE32K_CYCLES = ERASE32K_TIME_US * CLK_MHZ;
   localparam int CHIP_CYCLES = CHIP_TIME_US * CLK_MHZ;
   // link states
   typedef enum logic [2:0] {
      ST_OPC = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b011,
      ST_IGN = 3'b100
   } spi_state_t;
   // one program byte on its way to the array
   typedef struct packed {
      logic otp;
      logic [15:0] addr;
      logic [7:0] data;
   } prog_word_t;
   localparam int PROG_W = $bits(prog_word_t);
endpackage

//--- core/spi_flash_pin_interface.sv
/*
 serial flash device logic behind its pins, plus the program fifo.
 assumes the pins arrive asynchronous to clk and that sck runs far
 slower than clk (each sck level lasts several clk periods).
*/
`timescale 1ns/1ns

module prog_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg, rd_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   // one spare pointer bit tells full from empty
   assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign out_valid = wr_reg != rd_reg;
   assign out_data = mem[rd_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_reg + (AW+1)'(push);
         rd_reg <= rd_reg + (AW+1)'(pop);
      end
   end
endmodule

module spi_flash_pin_interface #(
   parameter int PROG_CYC = flash_pkg::PROG_CYCLES,
   parameter int ERASE4K_CYC = flash_pkg::ERASE4K_CYCLES,
   parameter int ERASE32K_CYC = flash_pkg::ERASE32K_CYCLES,
   parameter int CHIP_CYC = flash_pkg::CHIP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic pause_n,
   input wire logic write_protect_n,
   // device state
   output logic standby,
   output logic busy,
   output logic op_fail,
   output logic prog_ready
);
   // two-flop synchronisers, plus a third stage for edges
   logic [4:0] sync1_reg, sync2_reg;
   logic sck3_reg, cs3_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= 5'h17;
         sync2_reg <= 5'h17;
         sck3_reg <= 1'b0;
         cs3_reg <= 1'b1;
      end else begin
         sync1_reg <= {cs_n, sck, serial_in, pause_n, write_protect_n};
         sync2_reg <= sync1_reg;
         sck3_reg <= sync2_reg[3];
         cs3_reg <= sync2_reg[4];
      end
   end
   wire cs_s = sync2_reg[4];
   wire sck_s = sync2_reg[3];
   wire si_s = sync2_reg[2];
   // open pins read high thanks to the pad pull-ups
   wire pause_s = ~sync2_reg[1];
   wire locked = ~sync2_reg[0];
   // sck edges count only while selected and not paused; select edges always count
   wire live = ~cs_s & ~pause_s;
   wire sck_rise = live & sck_s & ~sck3_reg;
   wire sck_fall = live & ~sck_s & sck3_reg;
   wire cs_fall = ~cs_s & cs3_reg;
   wire cs_rise = cs_s & ~cs3_reg;

   // link state
   flash_pkg::spi_state_t state_reg, state_next;
   logic [2:0] bit_reg;
   logic [1:0] abyte_reg;
   logic [6:0] shift_reg;
   logic [7:0] opc_reg, out_reg;
   logic [15:0] addr_reg;
   logic addr_done_reg, wel_reg, so_reg;
   wire [7:0] rx_byte = {shift_reg, si_s};
   wire byte_done = sck_rise & (bit_reg == 3'h7);
   wire is_chip = opc_reg == flash_pkg::OP_CHIPA || opc_reg == flash_pkg::OP_CHIPB
      || opc_reg == flash_pkg::OP_CHIPC;
   wire is_e4 = opc_reg == flash_pkg::OP_ERASE4K;
   wire is_e32 = opc_reg == flash_pkg::OP_ERASE32A || opc_reg == flash_pkg::OP_ERASE32B;
   wire is_prog = opc_reg == flash_pkg::OP_PROG || opc_reg == flash_pkg::OP_OTP_PROG;
   wire is_otp = opc_reg == flash_pkg::OP_OTP_READ || opc_reg == flash_pkg::OP_OTP_PROG;
   wire is_read = opc_reg == flash_pkg::OP_READ || opc_reg == flash_pkg::OP_FREAD
      || opc_reg == flash_pkg::OP_OTP_READ;
   wire needs_addr = is_e4 | is_e32 | is_prog | is_read;
   wire rx_known = rx_byte == flash_pkg::OP_WREN || rx_byte == flash_pkg::OP_READ
      || rx_byte == flash_pkg::OP_FREAD || rx_byte == flash_pkg::OP_ERASE4K
      || rx_byte == flash_pkg::OP_ERASE32A || rx_byte == flash_pkg::OP_ERASE32B
      || rx_byte == flash_pkg::OP_CHIPA || rx_byte == flash_pkg::OP_CHIPB
      || rx_byte == flash_pkg::OP_CHIPC || rx_byte == flash_pkg::OP_PROG
      || rx_byte == flash_pkg::OP_OTP_READ || rx_byte == flash_pkg::OP_OTP_PROG;
   wire rx_addr = rx_byte != flash_pkg::OP_WREN && rx_byte != flash_pkg::OP_CHIPA
      && rx_byte != flash_pkg::OP_CHIPB && rx_byte != flash_pkg::OP_CHIPC;

   // next state on each completed byte
   always_comb begin
      state_next = state_reg;
      if (byte_done) begin
         case (state_reg)
            flash_pkg::ST_OPC: begin
               // an unknown opcode or one arriving while busy is dropped
               if (!rx_known || busy) begin
                  state_next = flash_pkg::ST_IGN;
               end else if (rx_addr) begin
                  state_next = flash_pkg::ST_ADDR;
               end else begin
                  state_next = flash_pkg::ST_DATA;
               end
            end
            flash_pkg::ST_ADDR: begin
               if (abyte_reg == flash_pkg::ADDR_BYTES) begin
                  state_next = (opc_reg == flash_pkg::OP_FREAD) ? flash_pkg::ST_DUMMY
                     : flash_pkg::ST_DATA;
               end
            end
            flash_pkg::ST_DUMMY: state_next = flash_pkg::ST_DATA;
            default: state_next = state_reg;
         endcase
      end
   end

   // fifo fill: program bytes only when enabled and unlocked
   flash_pkg::prog_word_t push_word, pop_word;
   logic pop_valid;
   wire prog_ok = wel_reg & ~locked & addr_done_reg & is_prog;
   wire push = byte_done & (state_reg == flash_pkg::ST_DATA) & prog_ok;
   assign push_word = '{otp: is_otp, addr: addr_reg, data: rx_byte};

   // link registers; a paused link simply sees no sck edges
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= flash_pkg::ST_OPC;
         bit_reg <= 3'h0;
         abyte_reg <= 2'h0;
         shift_reg <= 7'h00;
         opc_reg <= 8'h00;
         addr_reg <= 16'h0000;
         addr_done_reg <= 1'b0;
      end else if (cs_fall || cs_s) begin
         // select fall opens a fresh frame; deselect holds it idle
         state_reg <= flash_pkg::ST_OPC;
         // a stale opcode must not launch from a later, cut frame
         opc_reg <= 8'h00;
         bit_reg <= 3'h0;
         abyte_reg <= 2'h0;
         addr_done_reg <= 1'b0;
      end else if (sck_rise) begin
         // msb first, sampled on the rise
         shift_reg <= rx_byte[6:0];
         bit_reg <= bit_reg + 3'h1;
         state_reg <= state_next;
         if (byte_done && state_reg == flash_pkg::ST_OPC) begin
            // a refused opcode leaves nothing to launch at deselect
            opc_reg <= (rx_known && !busy) ? rx_byte : 8'h00;
         end
         if (byte_done && state_reg == flash_pkg::ST_ADDR) begin
            addr_reg <= {addr_reg[7:0], rx_byte};
            abyte_reg <= abyte_reg + 2'h1;
            addr_done_reg <= abyte_reg == flash_pkg::ADDR_BYTES;
         end
         // program wraps inside its 256 byte page; reads run on
         if (byte_done && state_reg == flash_pkg::ST_DATA && is_prog) begin
            addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
         end else if (byte_done && state_reg == flash_pkg::ST_DATA && is_read) begin
            addr_reg <= addr_reg + 16'h0001;
         end
      end
   end

   // arrays: main memory and the one-time security bytes
   logic [7:0] mem [flash_pkg::ARRAY_BYTES];
   logic [7:0] otp_mem [flash_pkg::OTP_BYTES];
   logic [15:0] er_ptr_reg, er_cnt_reg;
   logic er_act_reg;
   // unprogrammed security bytes read erased, with no reset of the array itself
   logic [flash_pkg::OTP_BYTES-1:0] otp_used_reg;
   wire [7:0] otp_rd = otp_used_reg[addr_reg[6:0]] ? otp_mem[addr_reg[6:0]]
      : flash_pkg::ERASED;
   wire [7:0] rd_byte = is_otp ? otp_rd : mem[addr_reg];

   // read data leaves on the fall, ready for the host's next rise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_reg <= 8'h00;
         so_reg <= 1'b0;
      end else if (sck_fall && state_reg == flash_pkg::ST_DATA && is_read) begin
         if (bit_reg == 3'h0) begin
            out_reg <= {rd_byte[6:0], 1'b0};
            so_reg <= rd_byte[7];
         end else begin
            out_reg <= {out_reg[6:0], 1'b0};
            so_reg <= out_reg[7];
         end
      end
   end
   assign serial_out = so_reg;
   // floats while deselected or paused
   assign serial_out_oe = live & is_read & (state_reg == flash_pkg::ST_DATA);

   // drain: flash bits only clear, so a byte that needs a 0->1 fails
   wire drain = pop_valid & ~er_act_reg;
   wire [6:0] otp_wa = pop_word.addr[6:0];
   wire [7:0] otp_old = otp_used_reg[otp_wa] ? otp_mem[otp_wa] : flash_pkg::ERASED;
   wire [7:0] old_byte = pop_word.otp ? otp_old : mem[pop_word.addr];
   wire verify_bad = drain & ((~old_byte & pop_word.data) != 8'h00);
   always_ff @(posedge clk) begin
      if (er_act_reg) begin
         mem[er_ptr_reg] <= flash_pkg::ERASED;
      end else if (drain && pop_word.otp) begin
         otp_mem[pop_word.addr[6:0]] <= old_byte & pop_word.data;
      end else if (drain) begin
         mem[pop_word.addr] <= old_byte & pop_word.data;
      end
   end
   // marks security bytes once written; no erase clears the marks, only sys_rst does
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         otp_used_reg <= '0;
      end else if (drain && pop_word.otp) begin
         otp_used_reg[otp_wa] <= 1'b1;
      end
   end

   prog_fifo #(.WIDTH(flash_pkg::PROG_W), .DEPTH(flash_pkg::FIFO_DEPTH)) fifo_u (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_ready(prog_ready),
      .in_data(push_word),
      .out_valid(pop_valid),
      .out_ready(~er_act_reg),
      .out_data(pop_word)
   );

   // launch at select rise only for a complete command
   logic [31:0] timer_reg;
   logic fail_reg;
   wire cmd_ok = wel_reg & ~busy & ~locked;
   wire go_erase = cs_rise & cmd_ok & (is_chip | ((is_e4 | is_e32) & addr_done_reg));
   wire go_prog = cs_rise & prog_ok & ~busy;
   wire go_wren = cs_rise & (opc_reg == flash_pkg::OP_WREN) & (state_reg == flash_pkg::ST_DATA);
   wire lock_hit = cs_rise & wel_reg & locked & (is_chip | (needs_addr & ~is_read
      & addr_done_reg));
   wire [15:0] er_mask = is_chip ? flash_pkg::MASK_CHIP : is_e32 ? flash_pkg::MASK_32K
      : flash_pkg::MASK_4K;
   // erase sizes pick their own time
   wire [31:0] er_time = is_chip ? 32'(CHIP_CYC) : is_e32 ? 32'(ERASE32K_CYC)
      : 32'(ERASE4K_CYC);
   wire fail_set = verify_bad | lock_hit | (push & ~prog_ready);
   // cleared as an enabled frame opens, so a program keeps its own failure
   wire fail_clr = cs_fall & wel_reg & ~busy;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_reg <= 32'h0000_0000;
         er_act_reg <= 1'b0;
         er_ptr_reg <= 16'h0000;
         er_cnt_reg <= 16'h0000;
         wel_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         // the timer ignores pause entirely
         if (go_erase) begin
            timer_reg <= er_time;
            er_act_reg <= 1'b1;
            er_ptr_reg <= addr_reg & ~er_mask;
            er_cnt_reg <= er_mask;
         end else begin
            if (go_prog) begin
               timer_reg <= 32'(PROG_CYC);
            end else if (timer_reg != 32'h0000_0000) begin
               timer_reg <= timer_reg - 32'h0000_0001;
            end
            if (er_act_reg) begin
               er_ptr_reg <= er_ptr_reg + 16'h0001;
               er_cnt_reg <= er_cnt_reg - 16'h0001;
               er_act_reg <= er_cnt_reg != 16'h0000;
            end
         end
         wel_reg <= go_wren | (wel_reg & ~go_erase & ~go_prog);
         // a new failure wins over the clear
         fail_reg <= fail_set | (fail_reg & ~fail_clr);
      end
   end
   assign busy = (timer_reg != 32'h0000_0000) | er_act_reg | pop_valid;
   // standby only once deselected and idle
   assign standby = cs_s & ~busy;
   assign op_fail = fail_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   float_desel_a: assert property (cs_s |-> !serial_out_oe)
      else $error("output driven while deselected");
   float_pause_a: assert property (pause_s |-> !serial_out_oe)
      else $error("output driven while paused");
   desel_ignore_a: assert property (cs_s && !cs_fall |=> state_reg == flash_pkg::ST_OPC
      && bit_reg == 3'h0)
      else $error("deselected link moved");
   pause_hold_a: assert property (pause_s && !cs_s |=> $stable(bit_reg) && $stable(shift_reg)
      && $stable(state_reg))
      else $error("paused link moved");
   timer_run_a: assert property (pause_s && timer_reg > 32'h0000_0001 && !go_erase
      && !go_prog |=> timer_reg == $past(timer_reg) - 32'h0000_0001)
      else $error("timed cycle disturbed");
   sample_rise_a: assert property (sck_rise && !cs_fall |=> shift_reg[0] == $past(si_s))
      else $error("input not taken on rise");
   out_fall_a: assert property ($changed(serial_out) |-> $past(sck_fall))
      else $error("output moved off a fall");
   standby_wait_a: assert property (busy |-> !standby)
      else $error("standby while busy");
   ignore_sticky_a: assert property (state_reg == flash_pkg::ST_IGN && !cs_s
      |=> state_reg == flash_pkg::ST_IGN)
      else $error("ignored frame resumed");
   early_desel_a: assert property (cs_rise && needs_addr && !addr_done_reg |-> !go_erase
      && !go_prog)
      else $error("partial command launched");
   lock_write_a: assert property (locked && cs_rise |-> !go_erase && !go_prog)
      else $error("locked device started a cycle");
   prog_cov: cover property (go_prog ##1 busy [*8]);
   erase_cov: cover property (go_erase && is_e4);
   read_cov: cover property (serial_out_oe && sck_fall);
   pause_cov: cover property (pause_s && !cs_s && busy);
endmodule

//--- tb/spi_host_model.sv
/*
 host controller model: mode 0 or 3 frames on the flash pins, 80 ns sck,
 with a pause that wiggles sck and data while paused.
 assumes a 100 MHz clk; its tasks are called by the bench.
*/
`timescale 1ns/1ns
module spi_host_model (
   // clock
   input wire logic clk,
   // pins toward the device
   output logic cs_n,
   output logic sck,
   output logic serial_in,
   output logic pause_n,
   // pins from the device
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   logic so_wire;
   // clock idle level: 0 for mode 0, 1 for mode 3; set by the bench
   logic cpol = 1'b0;
   // a released output reads as the inverse of its last bit, never that bit
   assign so_wire = serial_out_oe ? serial_out : ~serial_out;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      serial_in = 1'b0;
      pause_n = 1'b1;
   end
   // data line keeps changing between frames
   always @(posedge clk) begin
      if (cs_n) begin
         serial_in <= ~serial_in;
      end
   end
   // frame opens on the select fall
   task automatic sel();
      @(posedge clk);
      // park sck at the mode's idle level while still deselected
      if (sck != cpol) begin
         sck <= cpol;
         repeat (3) @(posedge clk);
      end
      cs_n <= 1'b0;
      repeat (3) @(posedge clk);
      // mode 3 opens with a fall, so every bit below ends on one
      if (cpol) begin
         sck <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   // frame closes on the select rise, sck back at its idle level
   // mode 3 leaves one spare rise at the end, harmless for reads
   task automatic desel();
      repeat (3) @(posedge clk);
      if (cpol) begin
         sck <= 1'b1;
         repeat (3) @(posedge clk);
      end
      cs_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // msb first; data set while low, answer taken at the rise
   // 8 clk per bit is 12.5 MHz, far under the host's sck limit
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in <= tx[i];
         repeat (5) @(posedge clk);
         rx[i] = so_wire;
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         sck <= 1'b0;
      end
   endtask
   // pause starts selected with sck low, and ends with sck low again
   task automatic hold_for(output logic oe_seen);
      // let the last fall reach the device before pausing
      repeat (4) @(posedge clk);
      pause_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         sck <= ~sck;
         serial_in <= ~serial_in;
         repeat (4) @(posedge clk);
      end
      oe_seen = serial_out_oe;
      pause_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

//--- tb/spi_flash_pin_interface_tb.sv
/*
 self-checking bench: host model drives the pins, a byte map model
 predicts every read byte; standby, busy, op_fail and the output enable are checked.
 assumes short timed-cycle parameters and an erased part after chip erase.
*/
`timescale 1ns/1ns
module spi_flash_pin_interface_tb;
   logic clk;
   logic sys_rst = 1'b1;
   logic write_protect_n = 1'b1;
   logic cs_n, sck, serial_in, pause_n, serial_out, serial_out_oe;
   logic standby, busy, op_fail, prog_ready;
   int errors = 0;
   int num_checks = 0;
   logic [7:0] mem[int];
   logic [7:0] otp[int];
   spi_flash_pin_interface #(.PROG_CYC(20), .ERASE4K_CYC(40), .ERASE32K_CYC(60),
      .CHIP_CYC(80)) dut_u (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .pause_n(pause_n), .write_protect_n(write_protect_n), .standby(standby),
      .busy(busy), .op_fail(op_fail), .prog_ready(prog_ready));
   spi_host_model host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .serial_in(serial_in),
      .pause_n(pause_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // never-written bytes read as erased
   function automatic logic [7:0] mexp(input int a);
      if (mem.exists(a)) begin
         return mem[a];
      end
      return 8'hff;
   endfunction
   // opcode then the last na address bytes, big-endian
   task automatic cmd(input logic [7:0] op, input int ad, input int na);
      logic [7:0] rx;
      host_u.sel();
      host_u.xfer(op, rx);
      for (int i = na - 1; i >= 0; i--) begin
         host_u.xfer(8'(ad >> (8 * i)), rx);
      end
   endtask
   task automatic wren();
      cmd(flash_pkg::OP_WREN, 0, 0);
      host_u.desel();
   endtask
   // bounded wait for the timed cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 70000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 70000) begin
         errors++;
      end
   endtask
   // read n bytes, pausing before the second one
   task automatic rd(input logic [7:0] op, input int a, input int n);
      logic [7:0] rx;
      logic [7:0] e;
      logic oe;
      cmd(op, a, 3);
      if (op == flash_pkg::OP_FREAD) begin
         host_u.xfer(8'h00, rx);
      end
      for (int i = 0; i < n; i++) begin
         if (i == 1) begin
            host_u.hold_for(oe);
            chk(oe, 1'b0);
         end
         host_u.xfer(8'h00, rx);
         e = (op == flash_pkg::OP_OTP_READ) ? otp[a & 127] : mexp((a + i) & 16'hffff);
         chk(rx, e);
      end
      chk(serial_out_oe, 1'b1);
      host_u.desel();
      chk(serial_out_oe, 1'b0);
   endtask
   // program bytes into the page model, wrapping in the low byte
   task automatic prog(input int a, input logic [7:0] d[$]);
      logic [7:0] rx;
      cmd(flash_pkg::OP_PROG, a, 3);
      foreach (d[k]) begin
         host_u.xfer(d[k], rx);
         mem[(a & 16'hff00) | ((a + k) & 8'hff)] = mexp((a & 16'hff00) | ((a + k) & 8'hff)) & d[k];
      end
      host_u.desel();
   endtask
   // cut a hang short, well past the ~77k cycles the tests take
   initial begin
      #950000;
      errors++;
      final_report();
   end
   initial begin
      int ad;
      int oa;
      logic [7:0] d0, d1, od;
      logic [7:0] ops[4];
      void'($urandom(67293));
      ops = '{flash_pkg::OP_ERASE32A, flash_pkg::OP_ERASE32B, flash_pkg::OP_CHIPB,
         flash_pkg::OP_CHIPC};
      ad = ($urandom_range(1, 15) << 12) | 32'h0000_03ff | ($urandom_range(0, 255) << 16);
      d0 = 8'($urandom) & 8'hfe;
      d1 = 8'($urandom);
      oa = $urandom_range(0, 127);
      od = 8'($urandom);
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(standby, 1'b1);
      chk(serial_out_oe, 1'b0);
      chk(busy, 1'b0);
      // chip erase: standby waits for the timed cycle
      wren();
      cmd(flash_pkg::OP_CHIPA, 0, 0);
      host_u.desel();
      chk(busy, 1'b1);
      chk(standby, 1'b0);
      wait_idle();
      chk(standby, 1'b1);
      // two bytes at the page end, the second wrapping to the page start
      wren();
      prog(ad, '{d0, d1});
      chk(busy, 1'b1);
      wait_idle();
      chk(op_fail, 1'b0);
      rd(flash_pkg::OP_READ, ad - 1, 4);
      // the first two bytes of that read again in mode 3, sck idling high
      host_u.cpol = 1'b1;
      rd(flash_pkg::OP_READ, ad - 1, 2);
      host_u.cpol = 1'b0;
      rd(flash_pkg::OP_FREAD, ad & 16'hff00, 2);
      // setting a cleared bit is reported
      wren();
      prog(ad, '{8'hff});
      wait_idle();
      chk(op_fail, 1'b1);
      // early deselect and unknown opcode start nothing
      wren();
      cmd(flash_pkg::OP_ERASE4K, ad, 1);
      host_u.desel();
      chk(busy, 1'b0);
      cmd(8'hab, 32'h0000_0006, 2);
      host_u.desel();
      chk(busy, 1'b0);
      // 4K block erase; the failure flag was already cleared as the early-deselect frame opened
      wren();
      cmd(flash_pkg::OP_ERASE4K, ad, 3);
      host_u.desel();
      chk(busy, 1'b1);
      wait_idle();
      chk(op_fail, 1'b0);
      for (int k = ad & 16'hf000; k < (ad & 16'hf000) + 4096; k++) begin
         if (mem.exists(k)) begin
            mem.delete(k);
         end
      end
      rd(flash_pkg::OP_READ, ad, 1);
      // erase codes without write enable do nothing
      foreach (ops[i]) begin
         cmd(ops[i], ad, 3);
         host_u.desel();
         chk(busy, 1'b0);
      end
      // locked array refuses a program
      write_protect_n <= 1'b0;
      wren();
      prog(ad + 16, '{8'h00});
      mem.delete((ad + 16) & 16'hffff);
      chk(op_fail, 1'b1);
      chk(busy, 1'b0);
      @(posedge clk);
      write_protect_n <= 1'b1;
      rd(flash_pkg::OP_READ, ad + 16, 1);
      // one-time register program and read back
      wren();
      cmd(flash_pkg::OP_OTP_PROG, oa, 3);
      host_u.xfer(od, d1);
      host_u.desel();
      wait_idle();
      otp[oa] = od;
      rd(flash_pkg::OP_OTP_READ, oa, 1);
      final_report();
   end
endmodule
